// ===== dac_port_pkg.sv
// constants shared by the serial command port of the dac front end
package dac_port_pkg;
	localparam int FRAME_BITS = 24;
	localparam int DATA_BITS = 16;
	localparam int CMD_MSB = 23;
	localparam int CMD_NIB_MSB = 19;
	localparam int CMD_NIB_LSB = 16;
	localparam int SYNC_STAGES = 2;

	typedef enum logic [3:0] {
		CMD_NOP_LO = 4'h0,
		CMD_CTRL_WR = 4'h1,
		CMD_CTRL_RD = 4'h2,
		CMD_INPUT_WR = 4'h3,
		CMD_INPUT_DAC_WR = 4'h4,
		CMD_INPUT_TO_DAC = 4'h5,
		CMD_CLEAR_WR = 4'h6,
		CMD_INPUT_RD = 4'h7,
		CMD_DAC_RD = 4'h8,
		CMD_CLEAR_RD = 4'h9,
		CMD_NOP_HI = 4'hF
	} cmd_code_t;

	// output_control field positions
	localparam int CTRL_VOLT_EN = 15;
	localparam int CTRL_CURR_EN = 14;
	localparam int CTRL_RSVD = 13;
	localparam int CTRL_UNIPOLAR = 12;
	localparam int CTRL_IRANGE_SW = 11;
	localparam int CTRL_IRANGE_4MA = 10;
	localparam int CTRL_CLR_DIS = 9;
	localparam int CTRL_CLR_MODE = 8;
	localparam int CTRL_HOLD_CLR = 7;
	localparam int CTRL_FAULT_EN = 6;
	localparam int CTRL_CLR_FLAG_EN = 5;
	localparam int CTRL_ST_SHORT = 4;
	localparam int CTRL_ST_OPEN = 3;
	localparam int CTRL_ST_CLEAR = 2;
	localparam logic [15:0] CTRL_WR_MASK = 16'hDFE0;

	localparam logic [23:0] SHIFT_RESET = 24'h000000;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] ZERO_CODE = 16'h0000;
endpackage

// ===== pin_sync_if.sv
// synchronised pin levels and edge pulses passed from the pin sampler to the core
`timescale 1ns/1ps
interface pin_sync_if;
	logic cs_n;
	logic cs_fall;
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic din;
	logic load_strobe_n;
	logic async_clear_n;
	logic volt_short_flag;
	logic curr_open_flag;

	modport src (
		output cs_n, cs_fall, cs_rise, sclk_rise, sclk_fall, din,
		output load_strobe_n, async_clear_n, volt_short_flag, curr_open_flag
	);
	modport dst (
		input cs_n, cs_fall, cs_rise, sclk_rise, sclk_fall, din,
		input load_strobe_n, async_clear_n, volt_short_flag, curr_open_flag
	);
endinterface

// ===== pin_sampler.sv
// two-flop synchronisers and edge finders for the serial port and control pins
`timescale 1ns/1ps
module pin_sampler (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic din_i,
	input wire logic load_strobe_n_i,
	input wire logic async_clear_n_i,
	input wire logic volt_short_flag_i,
	input wire logic curr_open_flag_i,
	pin_sync_if.src pins
);
	localparam int N = 7;
	// idle levels: selects and strobes high, clock/data/flags low
	localparam logic [N-1:0] IDLE = 7'h19;

	logic [N-1:0] raw;
	logic [N-1:0] meta;
	logic [N-1:0] stable;
	logic [1:0] prev;
	logic [N-1:0] next_meta;
	logic [N-1:0] next_stable;
	logic [1:0] next_prev;

	assign raw = {curr_open_flag_i, volt_short_flag_i, async_clear_n_i, load_strobe_n_i,
		din_i, sclk_i, cs_n_i};

	always_comb begin
		next_meta = raw;
		next_stable = meta;
		next_prev = stable[1:0];
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta <= IDLE;
			stable <= IDLE;
			prev <= IDLE[1:0];
		end else begin
			meta <= next_meta;
			stable <= next_stable;
			prev <= next_prev;
		end
	end

	// edges are found on the second stage only, never on the metastable one
	assign pins.cs_n = stable[0];
	assign pins.cs_fall = prev[0] & ~stable[0];
	assign pins.cs_rise = ~prev[0] & stable[0];
	assign pins.sclk_rise = ~prev[1] & stable[1];
	assign pins.sclk_fall = prev[1] & ~stable[1];
	assign pins.din = stable[2];
	assign pins.load_strobe_n = stable[3];
	assign pins.async_clear_n = stable[4];
	assign pins.volt_short_flag = stable[5];
	assign pins.curr_open_flag = stable[6];
endmodule

// ===== dac_serial_command_port.sv
// serial command port, register set and clear/fault logic of a 16-bit dac
// Summary of operation
// - chip select falling starts a 24-bit frame
// - command byte then data, msb first
// - shift data in on serial clock rise
// - serial output changes on serial clock fall
// - shift register keeps the latest 24 bits
// - chip select rising decodes and commits frame
// - readback data shifts out during next frame
// - low nibble decoded, 0000/1111 do nothing
// - code 0011 loads input register only
// - code 0100 loads input and dac registers
// - code 0101 copies input to dac register
// - 0x01 writes control, 0x02 reads it back
// - control stores D15..D14 and D12..D5, reads status D4..D2
// - D15 voltage enable, D14 current, D13 zero
// - D12 selects bipolar zero, unipolar one
// - dac updates on frame end or load strobe
// - clear input forces clear value or zero
// - fault on short, open, or clear state entered from the clear input
// - reset zeroes registers, outputs disabled
// - serial output floats while select high
// - status bits show short, open, clear state
`timescale 1ns/1ps
module dac_serial_command_port #(
	parameter int CODE_WIDTH = 16
) (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic din_i,
	output logic dout_o,
	output logic dout_oe_n_o,
	input wire logic load_strobe_n_i,
	input wire logic async_clear_n_i,
	input wire logic volt_short_flag_i,
	input wire logic curr_open_flag_i,
	output logic fault_o,
	output logic fault_oe_n_o,
	output logic [CODE_WIDTH-1:0] dac_code_o,
	output logic dac_update_o,
	output logic volt_out_enable_o,
	output logic curr_out_enable_o,
	output logic unipolar_o,
	output logic [15:0] output_control_o,
	output logic clear_state_flag_o
);
	pin_sync_if pins ();

	pin_sampler u_sampler (
		.mclk_i(mclk_i),
		.arst_n_i(arst_n_i),
		.cs_n_i(cs_n_i),
		.sclk_i(sclk_i),
		.din_i(din_i),
		.load_strobe_n_i(load_strobe_n_i),
		.async_clear_n_i(async_clear_n_i),
		.volt_short_flag_i(volt_short_flag_i),
		.curr_open_flag_i(curr_open_flag_i),
		.pins(pins)
	);

	// register state
	logic [dac_port_pkg::FRAME_BITS-1:0] shift_reg;
	logic [15:0] output_control;
	logic [CODE_WIDTH-1:0] input_reg;
	logic [CODE_WIDTH-1:0] dac_reg;
	logic [CODE_WIDTH-1:0] clear_reg;
	logic dac_update;

	logic [dac_port_pkg::FRAME_BITS-1:0] next_shift_reg;
	logic [15:0] next_output_control;
	logic [CODE_WIDTH-1:0] next_input_reg;
	logic [CODE_WIDTH-1:0] next_dac_reg;
	logic [CODE_WIDTH-1:0] next_clear_reg;
	logic next_dac_update;

	// serial output state
	logic dout;
	logic dout_oe_n;
	logic next_dout;
	logic next_dout_oe_n;

	// output stage state
	logic [CODE_WIDTH-1:0] dac_code;
	logic fault_oe_n;
	logic clear_state;
	logic [CODE_WIDTH-1:0] next_dac_code;
	logic next_fault_oe_n;
	logic next_clear_state;

	dac_port_pkg::cmd_code_t cmd;
	logic [15:0] frame_data;
	logic [15:0] ctrl_readback;

	function automatic logic [15:0] to_field(input logic [CODE_WIDTH-1:0] v);
		to_field = 16'(v);
	endfunction

	function automatic logic [CODE_WIDTH-1:0] from_field(input logic [15:0] v);
		from_field = CODE_WIDTH'(v);
	endfunction

	assign cmd = dac_port_pkg::cmd_code_t'(
		shift_reg[dac_port_pkg::CMD_NIB_MSB:dac_port_pkg::CMD_NIB_LSB]);
	assign frame_data = shift_reg[dac_port_pkg::DATA_BITS-1:0];

	// stored bits plus live status; D1 and D0 read as zero
	always_comb begin
		ctrl_readback = output_control & dac_port_pkg::CTRL_WR_MASK;
		ctrl_readback[dac_port_pkg::CTRL_ST_SHORT] = pins.volt_short_flag;
		ctrl_readback[dac_port_pkg::CTRL_ST_OPEN] = pins.curr_open_flag;
		ctrl_readback[dac_port_pkg::CTRL_ST_CLEAR] = clear_state;
	end

	// register next-state: shifting, frame commit and load strobe
	always_comb begin
		next_shift_reg = shift_reg;
		next_output_control = output_control;
		next_input_reg = input_reg;
		next_dac_reg = dac_reg;
		next_clear_reg = clear_reg;
		next_dac_update = 1'b0;
		if (!pins.cs_n && pins.sclk_rise) begin
			// oldest bit falls off the top, so stale bits flow on to a chained part
			next_shift_reg = {shift_reg[dac_port_pkg::FRAME_BITS-2:0], pins.din};
		end
		if (pins.cs_rise) begin
			unique case (cmd)
				dac_port_pkg::CMD_CTRL_WR: begin
					// reserved D13 is kept at zero whatever the host sends
					next_output_control = frame_data & dac_port_pkg::CTRL_WR_MASK;
				end
				dac_port_pkg::CMD_CTRL_RD: begin
					next_shift_reg[dac_port_pkg::DATA_BITS-1:0] = ctrl_readback;
				end
				dac_port_pkg::CMD_INPUT_WR: begin
					next_input_reg = from_field(frame_data);
				end
				dac_port_pkg::CMD_INPUT_DAC_WR: begin
					next_input_reg = from_field(frame_data);
					next_dac_reg = from_field(frame_data);
					next_dac_update = 1'b1;
				end
				dac_port_pkg::CMD_INPUT_TO_DAC: begin
					next_dac_reg = input_reg;
					next_dac_update = 1'b1;
				end
				dac_port_pkg::CMD_CLEAR_WR: begin
					next_clear_reg = from_field(frame_data);
				end
				dac_port_pkg::CMD_INPUT_RD: begin
					next_shift_reg[dac_port_pkg::DATA_BITS-1:0] = to_field(input_reg);
				end
				dac_port_pkg::CMD_DAC_RD: begin
					next_shift_reg[dac_port_pkg::DATA_BITS-1:0] = to_field(dac_reg);
				end
				dac_port_pkg::CMD_CLEAR_RD: begin
					next_shift_reg[dac_port_pkg::DATA_BITS-1:0] = to_field(clear_reg);
				end
				default: begin
					// no-op codes and undefined codes leave everything alone
					next_shift_reg = shift_reg;
				end
			endcase
		end
		// load strobe is level sensitive and follows the input register while low
		if (!pins.load_strobe_n) begin
			next_dac_reg = next_input_reg;
			next_dac_update = (next_input_reg != dac_reg) || next_dac_update;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			shift_reg <= dac_port_pkg::SHIFT_RESET;
			output_control <= dac_port_pkg::REG_RESET;
			input_reg <= CODE_WIDTH'(dac_port_pkg::REG_RESET);
			dac_reg <= CODE_WIDTH'(dac_port_pkg::REG_RESET);
			clear_reg <= CODE_WIDTH'(dac_port_pkg::REG_RESET);
			dac_update <= 1'b0;
		end else begin
			shift_reg <= next_shift_reg;
			output_control <= next_output_control;
			input_reg <= next_input_reg;
			dac_reg <= next_dac_reg;
			clear_reg <= next_clear_reg;
			dac_update <= next_dac_update;
		end
	end

	// serial output: top bit presented at frame start and after each falling edge
	always_comb begin
		next_dout = dout;
		next_dout_oe_n = dout_oe_n;
		if (pins.cs_n) begin
			next_dout_oe_n = 1'b1;
		end else begin
			next_dout_oe_n = 1'b0;
		end
		if (pins.cs_fall) begin
			next_dout = shift_reg[dac_port_pkg::CMD_MSB];
		end else if (!pins.cs_n && pins.sclk_fall) begin
			// host samples on the next rising edge, which also shifts the next bit up
			next_dout = shift_reg[dac_port_pkg::CMD_MSB];
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dout <= 1'b0;
			dout_oe_n <= 1'b1;
		end else begin
			dout <= next_dout;
			dout_oe_n <= next_dout_oe_n;
		end
	end

	// clear state and fault pin
	always_comb begin
		// clear input counts only while the disable bit is zero; hold bit forces it
		next_clear_state = (!pins.async_clear_n && !output_control[dac_port_pkg::CTRL_CLR_DIS])
			|| output_control[dac_port_pkg::CTRL_HOLD_CLR];
		next_dac_code = dac_reg;
		if (clear_state) begin
			if (output_control[dac_port_pkg::CTRL_CLR_MODE]) begin
				next_dac_code = clear_reg;
			end else begin
				next_dac_code = CODE_WIDTH'(dac_port_pkg::ZERO_CODE);
			end
		end
		// open drain: released unless a fault condition holds
		next_fault_oe_n = !(pins.volt_short_flag || pins.curr_open_flag
			|| (!pins.async_clear_n && clear_state));
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dac_code <= CODE_WIDTH'(dac_port_pkg::ZERO_CODE);
			fault_oe_n <= 1'b1;
			clear_state <= 1'b0;
		end else begin
			dac_code <= next_dac_code;
			fault_oe_n <= next_fault_oe_n;
			clear_state <= next_clear_state;
		end
	end

	assign dout_o = dout;
	assign dout_oe_n_o = dout_oe_n;
	assign fault_o = 1'b0;
	assign fault_oe_n_o = fault_oe_n;
	assign dac_code_o = dac_code;
	assign dac_update_o = dac_update;
	assign volt_out_enable_o = output_control[dac_port_pkg::CTRL_VOLT_EN];
	assign curr_out_enable_o = output_control[dac_port_pkg::CTRL_CURR_EN];
	assign unipolar_o = output_control[dac_port_pkg::CTRL_UNIPOLAR];
	assign output_control_o = output_control;
	assign clear_state_flag_o = clear_state;
endmodule

// ===== dac_serial_command_port_assertions.sv
// concurrent checks on the pins of the dac serial command port
`timescale 1ns/1ps
module dac_port_checker #(
	parameter int CODE_WIDTH = 16
) (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic load_strobe_n_i,
	input wire logic volt_short_flag_i,
	input wire logic dout_o,
	input wire logic dout_oe_n_o,
	input wire logic fault_oe_n_o,
	input wire logic [CODE_WIDTH-1:0] dac_code_o,
	input wire logic dac_update_o,
	input wire logic volt_out_enable_o,
	input wire logic curr_out_enable_o,
	input wire logic unipolar_o,
	input wire logic [15:0] output_control_o,
	input wire logic clear_state_flag_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!arst_n_i);

	chk_float_idle: assert property (cs_n_i [*6] |-> dout_oe_n_o)
		else $error("dout driven while select high");
	chk_drive_frame: assert property ($fell(cs_n_i) |-> ##[1:6] !dout_oe_n_o)
		else $error("dout not driven after select fall");
	chk_frame_quiet: assert property ((!cs_n_i && load_strobe_n_i) [*8] |-> !dac_update_o)
		else $error("dac update inside a frame");
	chk_ctrl_fixed: assert property (
		output_control_o[13] == 1'h0 && output_control_o[4:0] == 5'h00)
		else $error("control holds discarded bits");
	chk_enable_map: assert property (
		{volt_out_enable_o, curr_out_enable_o, unipolar_o}
		== {output_control_o[15:14], output_control_o[12]})
		else $error("enables differ from control");
	chk_reset_clean: assert property (
		$rose(arst_n_i) |-> output_control_o == 16'h0000 && dac_code_o == '0)
		else $error("registers not zero after reset");
	chk_short_fault: assert property (volt_short_flag_i [*5] |-> !fault_oe_n_o)
		else $error("no fault on shorted output");
	chk_clear_zero: assert property (
		(clear_state_flag_o && !output_control_o[8]) [*3] |-> dac_code_o == '0)
		else $error("hardware clear not zero scale");
	// slack of 2 to 5 mclk covers the pin synchroniser latency
	chk_dout_on_fall: assert property (
		$changed(dout_o) && !dout_oe_n_o && $past(!dout_oe_n_o, 2)
		|-> !$past(sclk_i, 2) && $past(sclk_i, 6))
		else $error("dout moved away from a clock fall");
	chk_upd_pulse: assert property (dac_update_o |=> !dac_update_o)
		else $error("update pulse longer than one cycle");

	cov_frame: cover property ($fell(cs_n_i));
	cov_update: cover property (dac_update_o);
	cov_clear_fault: cover property (clear_state_flag_o && !fault_oe_n_o);
endmodule

bind dac_serial_command_port dac_port_checker #(.CODE_WIDTH(CODE_WIDTH)) u_dac_port_checker (.*);

// ===== spi_host_model.sv
// serial host that frames 24-bit words and captures the returned bits
`timescale 1ns/1ps
module spi_host_model (
	output logic cs_n_o,
	output logic sclk_o,
	output logic din_o,
	input wire logic dout_i,
	input wire logic dout_oe_n_i
);
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		din_o = 1'b0;
	end

	// cpol low gives mode 0, high gives mode 3; clock stands still between frames
	task automatic xfer(input logic [23:0] tx, input logic cpol, output logic [23:0] rx);
		#7 sclk_o = cpol;
		#100 cs_n_o = 1'b0;
		#100;
		for (int i = 23; i >= 0; i--) begin
			sclk_o = 1'b0;
			din_o = tx[i];
			#100 sclk_o = 1'b1;
			// sampled late: the device answers a few mclk after each fall
			#99 rx[i] = dout_oe_n_i ? 1'bx : dout_i;
			#1;
		end
		sclk_o = cpol;
		#100 cs_n_o = 1'b1;
		din_o = ~din_o;
		#5000;
	endtask
endmodule

// ===== dac_serial_command_port_tb_top.sv
// self-checking bench of the dac serial command port
`timescale 1ns/1ps
module dac_serial_command_port_tb_top;
	logic mclk_i = 1'b0, arst_n_i = 1'b0, cs_n_i, sclk_i, din_i;
	logic load_strobe_n_i = 1'b1, async_clear_n_i = 1'b1;
	logic volt_short_flag_i = 1'b0, curr_open_flag_i = 1'b0;
	logic dout_o, dout_oe_n_o, fault_o, fault_oe_n_o, dac_update_o, clear_state_flag_o;
	logic volt_out_enable_o, curr_out_enable_o, unipolar_o;
	logic [15:0] dac_code_o, output_control_o;
	logic [23:0] rx;
	int fail_count = 0, samples_checked = 0, cycles = 0, upd_count = 0;

	always #12.5 mclk_i = ~mclk_i;

	dac_serial_command_port u_dac_serial_command_port (.*);
	spi_host_model u_spi_host_model (.cs_n_o(cs_n_i), .sclk_o(sclk_i), .din_o(din_i),
		.dout_i(dout_o), .dout_oe_n_i(dout_oe_n_o));

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	always @(posedge mclk_i) begin
		cycles++;
		if (dac_update_o === 1'b1)
			upd_count++;
		if (cycles == 40000) begin
			fail_count++;
			print_verdict();
		end
	end

	task automatic chk(input string n, input logic [23:0] s, e);
		samples_checked++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value %s exp %h seen %h", n, e, s);
		end
	endtask

	task automatic send(input logic [23:0] tx, input logic cpol = 1'b0);
		u_spi_host_model.xfer(tx, cpol, rx);
	endtask

	task automatic t_reset;
		chk("ctrl", 24'(output_control_o), 24'h0);
		chk("code", 24'(dac_code_o), 24'h0);
		chk("off", 24'({fault_o, volt_out_enable_o, curr_out_enable_o}), 24'h0);
		chk("oe", 24'({dout_oe_n_o, fault_oe_n_o}), 24'h3);
	endtask

	task automatic t_ctrl;
		send(24'h01F27F, 1'b1);
		chk("ctrl", 24'(output_control_o), 24'h00D260);
		chk("pins", 24'({volt_out_enable_o, curr_out_enable_o, unipolar_o}), 24'h7);
		@(posedge mclk_i) #2 volt_short_flag_i = 1'b1;
		curr_open_flag_i = 1'b1;
		send(24'hF20000, 1'b1);
		send(24'h0F0000);
		chk("rdctl", rx, 24'hF2D278);
		chk("fault", 24'(fault_oe_n_o), 24'h0);
		@(posedge mclk_i) #2 volt_short_flag_i = 1'b0;
		repeat (8) @(posedge mclk_i);
		#2 chk("open", 24'(fault_oe_n_o), 24'h0);
		curr_open_flag_i = 1'b0;
		repeat (8) @(posedge mclk_i);
		#2 chk("nofault", 24'(fault_oe_n_o), 24'h1);
		send(24'h010000);
		chk("keep", rx, 24'h0F0000);
	endtask

	task automatic t_dac;
		int u;
		u = upd_count;
		send(24'hA31234);
		chk("code", 24'(dac_code_o), 24'h0);
		send(24'h070000);
		send(24'h000000);
		chk("rdin", rx, 24'h071234);
		send(24'h05FFFF);
		chk("code", 24'(dac_code_o), 24'h1234);
		send(24'h04BEEF);
		send(24'h080000);
		send(24'h000000);
		chk("rddac", rx, 24'h08BEEF);
		chk("upd", 24'(upd_count - u), 24'h2);
	endtask

	task automatic t_undef;
		for (int c = 10; c < 15; c++) begin
			send({4'h0, 4'(c), 16'h0FFF});
			chk("code", 24'(dac_code_o), 24'h00BEEF);
			chk("ctrl", 24'(output_control_o), 24'h0);
		end
	endtask

	task automatic t_clear;
		send(24'h065555);
		send(24'h090000);
		send(24'h000000);
		chk("rdclr", rx, 24'h095555);
		send(24'h010100);
		@(posedge mclk_i) #2 async_clear_n_i = 1'b0;
		repeat (8) @(posedge mclk_i);
		#2 chk("clr", 24'(dac_code_o), 24'h005555);
		chk("flags", 24'({clear_state_flag_o, fault_oe_n_o}), 24'h2);
		send(24'h020000);
		send(24'h000000);
		chk("rdst", rx, 24'h020104);
		send(24'h010000);
		chk("zero", 24'(dac_code_o), 24'h0);
		send(24'h010200);
		chk("clrdis", 24'({clear_state_flag_o, dac_code_o}), 24'h00BEEF);
		@(posedge mclk_i) #2 async_clear_n_i = 1'b1;
		send(24'h010080);
		chk("hold", 24'({clear_state_flag_o, fault_oe_n_o, dac_code_o}), 24'h030000);
		send(24'h010000);
	endtask

	task automatic t_load;
		repeat (8) @(posedge mclk_i);
		send(24'h037777);
		chk("code", 24'(dac_code_o), 24'h00BEEF);
		@(posedge mclk_i) #2 load_strobe_n_i = 1'b0;
		repeat (6) @(posedge mclk_i);
		#2 load_strobe_n_i = 1'b1;
		repeat (4) @(posedge mclk_i);
		#2 chk("load", 24'(dac_code_o), 24'h007777);
	endtask

	initial begin
		repeat (10) @(posedge mclk_i);
		#2 arst_n_i = 1'b1;
		repeat (4) @(posedge mclk_i);
		#2;
		t_reset();
		t_ctrl();
		t_dac();
		t_undef();
		t_clear();
		t_load();
		print_verdict();
	end
endmodule
